// ===== pkg/ue0_pkg.sv
// Constants, register map and enumerations for the endpoint zero control block.
// Assumes a classic Wishbone slave with 32-bit data and one 100 MHz clock.
package ue0_pkg;
   // Register indices (byte address is four times the index)
   localparam logic [7:0] UE0_IDX_INDEX  = 8'h0e;
   localparam logic [7:0] UE0_IDX_IN_IRQ = 8'h02;
   localparam logic [7:0] UE0_IDX_CSR    = 8'h11;
   localparam logic [7:0] UE0_IDX_COUNT  = 8'h16;
   localparam logic [7:0] UE0_CSR_RESET  = 8'h00;
   localparam logic [3:0] UE0_INDEX_EP0  = 4'h0;
   // Control/status bit positions
   localparam int UE0_B_OUT_RDY  = 0;
   localparam int UE0_B_IN_RDY   = 1;
   localparam int UE0_B_STALLED  = 2;
   localparam int UE0_B_LAST     = 3;
   localparam int UE0_B_SU_END   = 4;
   localparam int UE0_B_FSTALL   = 5;
   localparam int UE0_B_SVC_OUT  = 6;
   localparam int UE0_B_SVC_SUE  = 7;
   localparam int UE0_B_IRQ_EP0  = 0;
   localparam logic [6:0] UE0_SETUP_LEN = 7'h08;
   localparam logic [6:0] UE0_MAX_PKT   = 7'h40;
   // Token kinds from the protocol engine
   typedef enum logic [1:0] {
      UE0_TOK_NONE  = 2'b00,
      UE0_TOK_SETUP = 2'b01,
      UE0_TOK_IN    = 2'b10,
      UE0_TOK_OUT   = 2'b11
   } ue0_tok_t;
   // Data stage direction
   typedef enum logic [1:0] {
      UE0_ST_IDLE = 2'b00,
      UE0_ST_TX   = 2'b01,
      UE0_ST_RX   = 2'b10
   } ue0_state_t;
   // Reply chosen for the protocol engine
   typedef enum logic [1:0] {
      UE0_HS_ACK   = 2'b00,
      UE0_HS_NAK   = 2'b01,
      UE0_HS_STALL = 2'b10,
      UE0_HS_DROP  = 2'b11
   } ue0_hs_t;
endpackage : ue0_pkg

// ===== design/ue0_ctrl.sv
// Endpoint zero control-transfer logic: mode tracking, handshake choice, CSR.
// Assumes a protocol engine on the same clock giving one-cycle token and
// packet-end pulses, and a classic Wishbone master with 32-bit data.
`default_nettype none
module ue0_ctrl
   import ue0_pkg::*;
#(
   parameter logic [6:0] MAX_PKT = UE0_MAX_PKT
) (
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   // Wishbone slave
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [9:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   // Protocol engine side
   input  wire logic        i_tok_stb,
   input  wire logic [1:0]  i_tok_kind,
   input  wire logic        i_rx_done,
   input  wire logic [6:0]  i_rx_len,
   input  wire logic        i_rx_ovf,
   input  wire logic        i_tx_done,
   input  wire logic [6:0]  i_tx_len,
   input  wire logic        i_stall_sent,
   output logic      [1:0]  o_hs,
   output logic             o_tx_mode,
   output logic             o_rx_mode,
   output logic             o_ep0_irq
);
   logic              ack_ff;
   logic       [31:0] rdat_ff;
   logic       [3:0]  index_ff;
   logic              out_rdy_ff;
   logic              in_rdy_ff;
   logic              stalled_ff;
   logic              last_ff;
   logic              su_end_ff;
   logic              fstall_ff;
   logic              irq_ff;
   logic       [6:0]  count_ff;
   ue0_state_t        state_ff;
   ue0_tok_t          tok_ff;
   logic              last_seen_ff;
   logic              rd_csr_ok;
   logic              wr_stb;
   logic              rd_stb;
   logic       [7:0]  wbyte;
   logic              csr_sel;
   logic              w_svc_out;
   logic              w_svc_sue;
   logic              w_in_rdy;
   logic              w_last;
   logic              w_fstall;
   logic              w_stall_clr;
   logic              setup_ok;
   logic              out_ok;
   logic              rx_oversize;
   logic              out_stall;
   logic              tx_ok;
   logic              tok_setup;
   logic              tok_in;
   logic              tok_out;
   logic              end_early;
   logic              rx_short;

   // Index match decode shared by read and write
   function automatic logic hit(input logic [9:0] adr, input logic [7:0] idx);
      hit = (adr[9:2] == idx);
   endfunction

   // Bus strobes, one access per request
   assign wr_stb    = i_wb_cyc & i_wb_stb & i_wb_we & ~ack_ff;
   assign rd_stb    = i_wb_cyc & i_wb_stb & ~i_wb_we & ~ack_ff;
   assign wbyte     = i_wb_sel[0] ? i_wb_dat[7:0] : 8'h00;
   assign csr_sel   = hit(i_wb_adr, UE0_IDX_CSR) & (index_ff == UE0_INDEX_EP0);
   assign w_svc_out = wr_stb & csr_sel & wbyte[UE0_B_SVC_OUT];
   assign w_svc_sue = wr_stb & csr_sel & wbyte[UE0_B_SVC_SUE];
   assign w_in_rdy  = wr_stb & csr_sel & wbyte[UE0_B_IN_RDY];
   assign w_last    = wr_stb & csr_sel & wbyte[UE0_B_LAST];
   assign w_fstall  = wr_stb & csr_sel & wbyte[UE0_B_FSTALL];
   assign w_stall_clr = wr_stb & csr_sel & ~wbyte[UE0_B_STALLED] & i_wb_sel[0];
   assign rd_csr_ok = rd_stb;

   // Token decode
   assign tok_setup = i_tok_stb & (ue0_tok_t'(i_tok_kind) == UE0_TOK_SETUP);
   assign tok_in    = i_tok_stb & (ue0_tok_t'(i_tok_kind) == UE0_TOK_IN);
   assign tok_out   = i_tok_stb & (ue0_tok_t'(i_tok_kind) == UE0_TOK_OUT);

   // Packet outcome classification
   assign rx_oversize = i_rx_ovf | (i_rx_len > MAX_PKT);
   assign out_stall   = (tok_ff == UE0_TOK_OUT) & (last_seen_ff | fstall_ff);
   assign setup_ok    = i_rx_done & (tok_ff == UE0_TOK_SETUP) & ~rx_oversize
                        & (i_rx_len == UE0_SETUP_LEN);
   assign out_ok      = i_rx_done & (tok_ff == UE0_TOK_OUT) & ~rx_oversize & ~out_stall;
   assign tx_ok       = i_tx_done & in_rdy_ff;
   assign rx_short    = i_rx_len < MAX_PKT;
   assign end_early   = ((state_ff == UE0_ST_TX) & (tok_setup | tok_out))
                        | ((state_ff == UE0_ST_RX) & (tok_setup | tok_in));

   // Handshake the engine uses for the current token
   always_comb begin
      o_hs = UE0_HS_ACK;
      if (fstall_ff) begin
         o_hs = UE0_HS_STALL;
      end else if (tok_ff == UE0_TOK_IN) begin
         if (last_seen_ff & ~in_rdy_ff) o_hs = UE0_HS_STALL;
         else if (~in_rdy_ff) o_hs = UE0_HS_NAK;
      end else if (tok_ff == UE0_TOK_OUT) begin
         if (last_seen_ff | rx_oversize) o_hs = UE0_HS_STALL;
         else if (out_rdy_ff) o_hs = UE0_HS_NAK;
      end else if (tok_ff == UE0_TOK_SETUP) begin
         if (rx_oversize) o_hs = UE0_HS_DROP;
      end
   end

   // Latest token, held for the data and handshake phase
   always_ff @(posedge i_clk) begin
      if (!i_nrst) tok_ff <= UE0_TOK_NONE;
      else if (i_tok_stb) tok_ff <= ue0_tok_t'(i_tok_kind);
   end

   // Data stage mode tracking
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         state_ff <= UE0_ST_IDLE;
      end else if (tok_setup) begin
         state_ff <= UE0_ST_IDLE;
      end else if (tok_in) begin
         state_ff <= UE0_ST_TX;
      end else if (tok_out) begin
         state_ff <= UE0_ST_RX;
      end else if (tx_ok & (i_tx_len < MAX_PKT)) begin
         state_ff <= UE0_ST_IDLE;
      end else if (out_ok & rx_short) begin
         state_ff <= UE0_ST_IDLE;
      end
   end

   // Received packet flag and byte count
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         out_rdy_ff <= 1'b0;
         count_ff   <= 7'h00;
      end else if (setup_ok | out_ok) begin
         out_rdy_ff <= 1'b1;
         count_ff   <= i_rx_len;
      end else if (w_svc_out) begin
         out_rdy_ff <= 1'b0;
      end
   end

   // Transmit packet ready; set from software, cleared by send or overwrite
   always_ff @(posedge i_clk) begin
      if (!i_nrst) in_rdy_ff <= 1'b0;
      else if (tx_ok | setup_ok | out_ok) in_rdy_ff <= 1'b0;
      else if (w_in_rdy) in_rdy_ff <= 1'b1;
   end

   // Last-packet mark: pulses into a transfer-scoped latch, self clearing
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         last_ff      <= 1'b0;
         last_seen_ff <= 1'b0;
      end else begin
         last_ff <= w_last & ~last_ff;
         if (tok_setup) last_seen_ff <= 1'b0;
         else if (w_last) last_seen_ff <= 1'b1;
      end
   end

   // Setup-ended flag, event set beats acknowledge clear
   always_ff @(posedge i_clk) begin
      if (!i_nrst) su_end_ff <= 1'b0;
      else if (end_early & ~last_seen_ff) su_end_ff <= 1'b1;
      else if (w_svc_sue) su_end_ff <= 1'b0;
   end

   // Force stall, cleared once the stall handshake has gone out
   always_ff @(posedge i_clk) begin
      if (!i_nrst) fstall_ff <= 1'b0;
      else if (i_stall_sent) fstall_ff <= 1'b0;
      else if (w_fstall) fstall_ff <= 1'b1;
   end

   // Stall-sent flag, held until software writes 0 to it
   always_ff @(posedge i_clk) begin
      if (!i_nrst) stalled_ff <= 1'b0;
      else if (i_stall_sent) stalled_ff <= 1'b1;
      else if (w_stall_clr) stalled_ff <= 1'b0;
   end

   // Endpoint interrupt pending; read of its register clears unless a new event lands
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         irq_ff <= 1'b0;
      end else if (setup_ok | out_ok | tx_ok | i_stall_sent
                   | (in_rdy_ff & (setup_ok | out_ok))
                   | (end_early & ~last_seen_ff)) begin
         irq_ff <= 1'b1;
      end else if (rd_stb & hit(i_wb_adr, UE0_IDX_IN_IRQ)) begin
         irq_ff <= 1'b0;
      end
   end

   // Index register
   always_ff @(posedge i_clk) begin
      if (!i_nrst) index_ff <= UE0_INDEX_EP0;
      else if (wr_stb & hit(i_wb_adr, UE0_IDX_INDEX) & i_wb_sel[0]) index_ff <= wbyte[3:0];
   end

   // Read data and single-cycle acknowledge
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         ack_ff  <= 1'b0;
         rdat_ff <= 32'h0000_0000;
      end else begin
         ack_ff  <= i_wb_cyc & i_wb_stb & ~ack_ff;
         rdat_ff <= 32'h0000_0000;
         if (rd_csr_ok) begin
            if (csr_sel) begin
               rdat_ff[UE0_B_OUT_RDY] <= out_rdy_ff;
               rdat_ff[UE0_B_IN_RDY]  <= in_rdy_ff;
               rdat_ff[UE0_B_STALLED] <= stalled_ff;
               rdat_ff[UE0_B_LAST]    <= last_ff;
               rdat_ff[UE0_B_SU_END]  <= su_end_ff;
               rdat_ff[UE0_B_FSTALL]  <= fstall_ff;
            end else if (hit(i_wb_adr, UE0_IDX_IN_IRQ)) begin
               rdat_ff[UE0_B_IRQ_EP0] <= irq_ff;
            end else if (hit(i_wb_adr, UE0_IDX_COUNT) & (index_ff == UE0_INDEX_EP0)) begin
               rdat_ff[6:0] <= count_ff;
            end else if (hit(i_wb_adr, UE0_IDX_INDEX)) begin
               rdat_ff[3:0] <= index_ff;
            end
         end
      end
   end

   assign o_wb_ack  = ack_ff;
   assign o_wb_dat  = rdat_ff;
   assign o_tx_mode = (state_ff == UE0_ST_TX);
   assign o_rx_mode = (state_ff == UE0_ST_RX);
   assign o_ep0_irq = irq_ff;
endmodule // ue0_ctrl
`default_nettype wire

// ===== verif/ue0_ctrl_assertions.sv
// Concurrent checks on the endpoint zero control block, seen from its ports.
// Assumes one clock domain and the synchronous active-low reset.
`default_nettype none
module ue0_ctrl_chk
   import ue0_pkg::*;
#(
   parameter logic [6:0] MAX_PKT = UE0_MAX_PKT
) (
   input wire logic        i_clk,
   input wire logic        i_nrst,
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic        o_wb_ack,
   input wire logic [31:0] o_wb_dat,
   input wire logic        i_tok_stb,
   input wire logic [1:0]  i_tok_kind,
   input wire logic        i_rx_done,
   input wire logic [6:0]  i_rx_len,
   input wire logic        i_tx_done,
   input wire logic [6:0]  i_tx_len,
   input wire logic        i_stall_sent,
   input wire logic        o_tx_mode,
   input wire logic        o_rx_mode,
   input wire logic        o_ep0_irq
);
   logic [1:0] kind_ff;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // Kind of the last token, used to classify packet ends
   always_ff @(posedge i_clk) begin
      if (!i_nrst) kind_ff <= UE0_TOK_NONE;
      else if (i_tok_stb) kind_ff <= i_tok_kind;
   end
   wire logic su_end = i_rx_done && kind_ff == UE0_TOK_SETUP;
   wire logic out_end = i_rx_done && kind_ff == UE0_TOK_OUT;
   wire logic tok_in = i_tok_stb && i_tok_kind == UE0_TOK_IN;
   wire logic tok_su = i_tok_stb && i_tok_kind == UE0_TOK_SETUP;
   wire logic tok_out = i_tok_stb && i_tok_kind == UE0_TOK_OUT;
   property p_ack_take; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack; endproperty
   a_ack_take: assert property (p_ack_take) else $error("bus answer not a one-cycle ack");
   property p_dat_idle; !o_wb_ack |-> o_wb_dat == 32'h0; endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
   property p_setup_bad; su_end && i_rx_len != UE0_SETUP_LEN |=> !$rose(o_ep0_irq); endproperty
   a_setup_bad: assert property (p_setup_bad) else $error("bad setup raised irq");
   property p_setup_ok; su_end && i_rx_len == UE0_SETUP_LEN |=> o_ep0_irq; endproperty
   a_setup_ok: assert property (p_setup_ok) else $error("setup gave no irq");
   property p_rx_irq; out_end && i_rx_len <= MAX_PKT |=> o_ep0_irq; endproperty
   a_rx_irq: assert property (p_rx_irq) else $error("out packet gave no irq");
   property p_tx_irq; i_tx_done |=> o_ep0_irq; endproperty
   a_tx_irq: assert property (p_tx_irq) else $error("sent packet gave no irq");
   property p_stall_irq; i_stall_sent |=> o_ep0_irq; endproperty
   a_stall_irq: assert property (p_stall_irq) else $error("stall gave no irq");
   property p_tx_enter; tok_in && !o_rx_mode |=> o_tx_mode; endproperty
   a_tx_enter: assert property (p_tx_enter) else $error("in token left tx mode off");
   property p_tx_leave; tok_su || tok_out || (i_tx_done && i_tx_len < MAX_PKT) |=> !o_tx_mode;
   endproperty
   a_tx_leave: assert property (p_tx_leave) else $error("tx mode not left");
   property p_rx_enter; tok_out && !o_tx_mode && !o_rx_mode |=> o_rx_mode; endproperty
   a_rx_enter: assert property (p_rx_enter) else $error("out token left rx mode off");
   property p_rx_leave; tok_su || tok_in || (out_end && i_rx_len < MAX_PKT) |=> !o_rx_mode;
   endproperty
   a_rx_leave: assert property (p_rx_leave) else $error("rx mode not left");
   c_out: cover property (out_end);
   c_tx: cover property (i_tx_done);
   c_stall: cover property (i_stall_sent);
endmodule // ue0_ctrl_chk
`default_nettype wire

// ===== verif/ue0_host_model.sv
// Behavioural host and protocol engine facing endpoint zero.
// Assumes the block gives its reply on o_hs from the cycle after a token.
`default_nettype none
module ue0_host
   import ue0_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic [1:0] i_hs,
   output logic            o_tok_stb,
   output logic      [1:0] o_tok_kind,
   output logic            o_rx_done,
   output logic      [6:0] o_rx_len,
   output logic            o_rx_ovf,
   output logic            o_tx_done,
   output logic      [6:0] o_tx_len,
   output logic            o_stall_sent
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle engine at time zero
   initial {o_tok_stb, o_tok_kind, o_rx_done, o_rx_len, o_rx_ovf} = '0;
   initial {o_tx_done, o_tx_len, o_stall_sent} = '0;
   // Token, reply taken gap cycles later, then the matching packet-end pulse
   task automatic xfer(input ue0_tok_t k, input logic [6:0] n, input int gap,
                       output logic [1:0] hs);
      @(posedge i_clk);
      o_tok_stb <= 1'b1;
      o_tok_kind <= k;
      // Data phase length is known from the token on, so the reply can judge it
      o_tx_len <= n;
      o_rx_len <= n;
      @(posedge i_clk);
      o_tok_stb <= 1'b0;
      o_tok_kind <= ~k;
      repeat (gap) @(posedge i_clk);
      hs = i_hs;
      o_tx_done <= hs == UE0_HS_ACK && k == UE0_TOK_IN;
      o_rx_done <= hs == UE0_HS_ACK && k != UE0_TOK_IN;
      o_stall_sent <= hs == UE0_HS_STALL;
      o_tx_len <= n;
      o_rx_len <= n;
      @(posedge i_clk);
      {o_tx_done, o_rx_done, o_stall_sent} <= 3'b000;
      o_tx_len <= ~n;
      o_rx_len <= ~n;
   endtask
endmodule // ue0_host
`default_nettype wire

// ===== verif/usb_endpoint0_control_transfer_test.sv
// Self-checking bench: firmware over Wishbone, host model on the engine side.
// Assumes one 100 MHz clock and the checker bound to the block.
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module usb_endpoint0_control_transfer_test
   import ue0_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [9:0] A_CSR = {UE0_IDX_CSR, 2'b00};
   localparam logic [9:0] A_IRQ = {UE0_IDX_IN_IRQ, 2'b00};
   logic        i_clk = 1'b0;
   logic        i_nrst = 1'b0;
   logic        i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
   logic [9:0]  i_wb_adr = '0;
   logic [3:0]  i_wb_sel = '0;
   logic [31:0] i_wb_dat = '0, o_wb_dat;
   logic        o_wb_ack, i_tok_stb, i_rx_done, i_rx_ovf, i_tx_done, i_stall_sent;
   logic        o_tx_mode, o_rx_mode, o_ep0_irq;
   logic [1:0]  i_tok_kind, o_hs, h;
   logic [6:0]  i_rx_len, i_tx_len;
   logic [7:0]  q;
   int          n_mismatch = 0, n_checks = 0;
   // Clock
   always #5 i_clk = ~i_clk;
   ue0_ctrl ue0_ctrl_inst (.*);
   ue0_host ue0_host_inst (.i_clk(i_clk), .i_hs(o_hs), .o_tok_stb(i_tok_stb),
      .o_tok_kind(i_tok_kind), .o_rx_done(i_rx_done), .o_rx_len(i_rx_len),
      .o_rx_ovf(i_rx_ovf), .o_tx_done(i_tx_done), .o_tx_len(i_tx_len),
      .o_stall_sent(i_stall_sent));
   // Classic single bus cycle; read data taken at the ack edge
   task automatic wb(input logic we, input logic [9:0] a, input logic [7:0] d);
      int t = 0;
      @(posedge i_clk);
      {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_sel} <= {2'b11, we, a, 4'h1};
      i_wb_dat <= {24'h0, d};
      do begin
         @(posedge i_clk);
         t++;
      end while (o_wb_ack !== 1'b1 && t < 20);
      if (t >= 20) n_mismatch++;
      q = o_wb_dat[7:0];
      {i_wb_cyc, i_wb_stb} <= 2'b00;
      i_wb_adr <= ~a;
      i_wb_dat <= ~i_wb_dat;
   endtask
   // Main sequence
   initial begin
      repeat (4) @(posedge i_clk);
      i_nrst <= 1'b1;
      wb(1'b1, {UE0_IDX_INDEX, 2'b00}, 8'h00);
      wb(1'b0, A_CSR, 8'h00); `CHK(q, UE0_CSR_RESET)
      wb(1'b0, 10'h3fc, 8'h00); `CHK(q, 8'h00)
      $display("test reset done");
      ue0_host_inst.xfer(UE0_TOK_SETUP, 7'h07, 1, h);
      wb(1'b0, A_IRQ, 8'h00); `CHK(q, 8'h00)
      ue0_host_inst.xfer(UE0_TOK_SETUP, 7'h08, 1, h);
      wb(1'b0, A_IRQ, 8'h00); `CHK(q, 8'h01)
      wb(1'b0, A_IRQ, 8'h00); `CHK(q, 8'h00)
      wb(1'b0, {UE0_IDX_COUNT, 2'b00}, 8'h00); `CHK(q, 8'h08)
      wb(1'b1, A_CSR, 8'h40);
      wb(1'b0, A_CSR, 8'h00); `CHK(q[7:0], 8'h00)
      $display("test setup done");
      ue0_host_inst.xfer(UE0_TOK_IN, 7'h00, 1, h); `CHK(h, UE0_HS_NAK)
      wb(1'b0, A_IRQ, 8'h00); `CHK(q, 8'h00)
      `CHK(o_tx_mode, 1'b1)
      wb(1'b1, A_CSR, 8'h0a);
      wb(1'b0, A_CSR, 8'h00); `CHK(q[3:1], 3'b001)
      ue0_host_inst.xfer(UE0_TOK_IN, 7'h05, 1, h); `CHK(h, UE0_HS_ACK)
      wb(1'b0, A_IRQ, 8'h00); `CHK(q, 8'h01)
      wb(1'b0, A_CSR, 8'h00); `CHK(q[1], 1'b0)
      `CHK(o_tx_mode, 1'b0)
      $display("test in stage done");
      wb(1'b1, A_CSR, 8'h02);
      ue0_host_inst.xfer(UE0_TOK_SETUP, 7'h08, 2, h);
      wb(1'b0, A_CSR, 8'h00); `CHK(q[1:0], 2'b01)
      wb(1'b1, A_CSR, 8'h40);
      ue0_host_inst.xfer(UE0_TOK_IN, 7'h00, 1, h);
      ue0_host_inst.xfer(UE0_TOK_OUT, 7'h00, 1, h);
      wb(1'b0, A_CSR, 8'h00); `CHK(q[4], 1'b1)
      wb(1'b1, A_CSR, 8'h80);
      wb(1'b0, A_CSR, 8'h00); `CHK({q[7], q[4]}, 2'b00)
      $display("test setup end done");
      ue0_host_inst.xfer(UE0_TOK_SETUP, 7'h08, 1, h);
      wb(1'b1, A_CSR, 8'h40);
      ue0_host_inst.xfer(UE0_TOK_OUT, UE0_MAX_PKT, 1, h);
      wb(1'b0, A_CSR, 8'h00); `CHK(q[0], 1'b1)
      `CHK(o_rx_mode, 1'b1)
      wb(1'b1, A_CSR, 8'h48);
      ue0_host_inst.xfer(UE0_TOK_OUT, 7'h00, 1, h); `CHK(h, UE0_HS_STALL)
      wb(1'b0, A_CSR, 8'h00); `CHK(q[2], 1'b1)
      wb(1'b0, A_IRQ, 8'h00); `CHK(q, 8'h01)
      wb(1'b1, A_CSR, 8'h00);
      wb(1'b0, A_CSR, 8'h00); `CHK(q[2], 1'b0)
      $display("test out stage done");
      wb(1'b1, A_CSR, 8'h20);
      wb(1'b0, A_CSR, 8'h00); `CHK(q[5], 1'b1)
      ue0_host_inst.xfer(UE0_TOK_IN, 7'h00, 3, h); `CHK(h, UE0_HS_STALL)
      wb(1'b0, A_CSR, 8'h00); `CHK(q[5:2], 4'b0001)
      $display("test force stall done");
      end_of_test();
   end
   // Watchdog against a hang
   initial begin
      repeat (5000) @(posedge i_clk);
      n_mismatch++;
      end_of_test();
   end
   // Counts, verdict and end of run
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
endmodule // usb_endpoint0_control_transfer_test
bind ue0_ctrl ue0_ctrl_chk #(.MAX_PKT(MAX_PKT)) ue0_ctrl_chk_inst (.*);
`default_nettype wire
